// >>> hdl/prxa_cfg.svh
`ifndef PRXA_CFG_SVH
`define PRXA_CFG_SVH

// Register offsets
`define PRXA_ADDR_CH1_TUNE 6'h2e
`define PRXA_ADDR_DEC_OPT 6'h2f
`define PRXA_ADDR_CH2_TUNE 6'h30
`define PRXA_ADDR_CH1_BASE 6'h32
`define PRXA_ADDR_CH1_MARGIN 6'h33
`define PRXA_ADDR_CH1_TRIP 6'h34

// Reset values and writable masks
`define PRXA_RST_TUNE 16'h4400
`define PRXA_RST_DEC 16'h0000
`define PRXA_MASK_TUNE 16'hfbfd
`define PRXA_MASK_DEC 16'h9e7f

// Tuning word fields
`define PRXA_F_KEEP_ON 15
`define PRXA_F_LVL_HI 14
`define PRXA_F_LVL_LO 11
`define PRXA_F_FAST 9
`define PRXA_F_BLANK_HI 8
`define PRXA_F_BLANK_LO 7
`define PRXA_F_EXT_HI 6
`define PRXA_F_EXT_LO 3
`define PRXA_F_HOLD_DIS 2
`define PRXA_F_TTYPE 0

// Decoder option fields, channel 2 sits six bits above channel 1
`define PRXA_F_LOOP_DLY 15
`define PRXA_F_LONG1 6
`define PRXA_F_PER_OFF1 5
`define PRXA_F_DUTY_OFF1 4
`define PRXA_F_CLR1 3
`define PRXA_F_CH2_SHIFT 6
`define PRXA_F_SYNC_HI 2
`define PRXA_F_SYNC_LO 0

// Timing
`define PRXA_CLK_NS 10
`define PRXA_CLK_PS 10000
`define PRXA_TOSC_PS 62500
`define PRXA_FILT_189K 16
`define PRXA_FILT_SLOW 24
`define PRXA_BLANK_SHORT_US 128
`define PRXA_BLANK_MID_US 5000
`define PRXA_BLANK_LONG_US 10000
`define PRXA_LOOP_DLY_US 20000
`define PRXA_SYNC_STEP_US 2
`define PRXA_STG_FILT_US 10

// Current levels, one step is 62.5 uA
`define PRXA_LVL_LSB_NA 62500
`define PRXA_THR_OFS_NA 5500000
`define PRXA_THR_SPAN_NA 9500000
`define PRXA_THR_CODES 16
`define PRXA_FAST_STEP 8

`endif

// >>> hdl/prxa_pkg.sv
package prxa_pkg;

  typedef logic [9:0] prxa_lvl_t;

  typedef enum logic [1:0] {
    PRXA_LOOP_IDLE,
    PRXA_LOOP_WAIT,
    PRXA_LOOP_FIRE
  } prxa_loop_t;

endpackage

// >>> hdl/prxa_rx_settings.sv
`timescale 1ns/1ps
`default_nettype none
`include "prxa_cfg.svh"

module prxa_rx_settings #(
  parameter int unsigned BLANK_SHORT_CYC = `PRXA_BLANK_SHORT_US * 1000 / `PRXA_CLK_NS,
  parameter int unsigned BLANK_MID_CYC = `PRXA_BLANK_MID_US * 1000 / `PRXA_CLK_NS,
  parameter int unsigned BLANK_LONG_CYC = `PRXA_BLANK_LONG_US * 1000 / `PRXA_CLK_NS,
  parameter int unsigned LOOP_DLY_CYC = `PRXA_LOOP_DLY_US * 1000 / `PRXA_CLK_NS
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  // Register port
  input wire logic [5:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [15:0] reg_rdata_o,
  input wire logic prog_end_i,
  output logic prog_done_o,
  // Receive path
  input wire logic rate_189k_i,
  input wire logic [1:0] rx_i,
  input wire logic [1:0] stg_i,
  input wire logic [1:0] sensor_start_i,
  input wire logic [1:0] frame_active_i,
  input wire logic [1:0] meas_valid_i,
  input wire logic [1:0][9:0] meas_level_i,
  output logic [1:0] rx_data_o,
  output logic [1:0] chan_off_o,
  output logic [1:0][9:0] thr_level_o,
  // Decoder hooks
  input wire logic [1:0] long_bit_i,
  input wire logic [1:0] start_bit_err_i,
  input wire logic [1:0] dec_err_i,
  output logic [1:0] long_bit_err_o,
  output logic [1:0] period_meas_en_o,
  output logic [1:0] duty_check_en_o,
  output logic [1:0] bit_cnt_clr_o,
  output logic fll_reset_o,
  // Sync pulses
  input wire logic [1:0] auto_sync_i,
  input wire logic [1:0] sync_trig_i,
  output logic [1:0] sync_o
);

  localparam int SYNC_STEP_CYC = `PRXA_SYNC_STEP_US * 1000 / `PRXA_CLK_NS;
  localparam int STG_CYC = (`PRXA_STG_FILT_US * 1000 + `PRXA_CLK_NS - 1) / `PRXA_CLK_NS;
  localparam int THR_OFS = `PRXA_THR_OFS_NA / `PRXA_LVL_LSB_NA;
  localparam int THR_STEP2 = 2 * `PRXA_THR_SPAN_NA / (`PRXA_THR_CODES * `PRXA_LVL_LSB_NA);
  localparam logic [10:0] THR_OFS_W = 11'(THR_OFS);
  localparam logic [10:0] LVL_MAX = 11'h3ff;

  // Deglitch length in clock cycles, rounded up
  function automatic logic [9:0] prxa_filt_cyc(input logic [5:0] n);
    int t;
    t = (int'(n) * `PRXA_TOSC_PS + `PRXA_CLK_PS - 1) / `PRXA_CLK_PS;
    return t[9:0];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  logic [15:0] ch1_tune_r;
  logic [15:0] dec_opt_r;
  logic [15:0] ch2_tune_r;
  logic prog_done_r;
  logic [15:0] rdata_r;
  logic wr_ok;
  prxa_pkg::prxa_lvl_t base_lvl [2];
  prxa_pkg::prxa_lvl_t margin_lvl [2];
  prxa_pkg::prxa_lvl_t trip_lvl [2];

  assign wr_ok = reg_wr_i & ~prog_done_r;

  // Settings are writable only during programming
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ch1_tune_r <= `PRXA_RST_TUNE;
      dec_opt_r <= `PRXA_RST_DEC;
      ch2_tune_r <= `PRXA_RST_TUNE;
    end else if (wr_ok) begin
      case (reg_addr_i)
        `PRXA_ADDR_CH1_TUNE: ch1_tune_r <= reg_wdata_i & `PRXA_MASK_TUNE;
        `PRXA_ADDR_DEC_OPT: dec_opt_r <= reg_wdata_i & `PRXA_MASK_DEC;
        `PRXA_ADDR_CH2_TUNE: ch2_tune_r <= reg_wdata_i & `PRXA_MASK_TUNE;
        default: ;
      endcase
    end
  end

  // End of programming flag
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      prog_done_r <= 1'b0;
    end else if (prog_end_i) begin
      prog_done_r <= 1'b1;
    end
  end

  // Read data, one cycle after the strobe
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_r <= 16'h0000;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        `PRXA_ADDR_CH1_TUNE: rdata_r <= ch1_tune_r;
        `PRXA_ADDR_DEC_OPT: rdata_r <= dec_opt_r;
        `PRXA_ADDR_CH2_TUNE: rdata_r <= ch2_tune_r;
        `PRXA_ADDR_CH1_BASE: rdata_r <= {6'h00, base_lvl[0]};
        `PRXA_ADDR_CH1_MARGIN: rdata_r <= {6'h00, margin_lvl[0]};
        `PRXA_ADDR_CH1_TRIP: rdata_r <= {6'h00, trip_lvl[0]};
        default: rdata_r <= 16'h0000;
      endcase
    end
  end

  assign reg_rdata_o = rdata_r;
  assign prog_done_o = prog_done_r;

  ////////////////////////////////////////////////////////////////////////////
  // Timers: 0 and 1 blanking, 2 loop restart, 3 sync offset

  prxa_tmr_if tmr [4] ();

  for (genvar i = 0; i < 4; i++) begin : g_tmr
    prxa_timer u_timer (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .t(tmr[i])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per channel receive path

  logic [1:0] err_any;

  for (genvar g = 0; g < 2; g++) begin : g_ch
    localparam int SH = g * `PRXA_F_CH2_SHIFT;
    logic [15:0] tune;
    logic rx_s1_r;
    logic rx_s2_r;
    logic stg_s1_r;
    logic stg_s2_r;
    logic [9:0] filt_len;
    logic [9:0] flt_cnt_r;
    logic rx_flt_r;
    logic rx_data_r;
    logic [9:0] stg_cnt_r;
    logic stg_fault_r;
    logic chan_off_r;
    logic [10:0] base_r;
    logic [10:0] peak_r;
    logic [10:0] meas;
    logic [10:0] step;
    logic freeze;
    logic [10:0] ofs_fix;
    logic [10:0] ofs_ad;
    logic [10:0] thr_sum;
    logic [9:0] thr_r;
    logic [9:0] margin_r;
    logic long_err_r;
    logic clr_r;

    assign tune = (g == 0) ? ch1_tune_r : ch2_tune_r;

    // Pin synchronisers
    always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
        rx_s1_r <= 1'b0;
        rx_s2_r <= 1'b0;
        stg_s1_r <= 1'b0;
        stg_s2_r <= 1'b0;
      end else begin
        rx_s1_r <= rx_i[g];
        rx_s2_r <= rx_s1_r;
        stg_s1_r <= stg_i[g];
        stg_s2_r <= stg_s1_r;
      end
    end

    // Deglitch length from rate and extension
    always_comb begin
      if (rate_189k_i) begin
        filt_len = prxa_filt_cyc(6'(`PRXA_FILT_189K) +
                                 {2'b00, tune[`PRXA_F_EXT_HI:`PRXA_F_EXT_LO]});
      end else begin
        filt_len = prxa_filt_cyc(6'(`PRXA_FILT_SLOW) +
                                 {2'b00, tune[`PRXA_F_EXT_HI:`PRXA_F_EXT_LO]});
      end
    end

    // Input follows only after a stable run of filt_len cycles
    always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
        flt_cnt_r <= 10'h000;
        rx_flt_r <= 1'b0;
      end else if (rx_s2_r == rx_flt_r) begin
        flt_cnt_r <= 10'h000;
      end else if (flt_cnt_r >= filt_len - 10'h001) begin
        rx_flt_r <= rx_s2_r;
        flt_cnt_r <= 10'h000;
      end else begin
        flt_cnt_r <= flt_cnt_r + 10'h001;
      end
    end

    // Startup blanking
    assign tmr[g].start = sensor_start_i[g];
    always_comb begin
      case (tune[`PRXA_F_BLANK_HI:`PRXA_F_BLANK_LO])
        2'b01: tmr[g].load = 21'(BLANK_MID_CYC);
        2'b10: tmr[g].load = 21'(BLANK_LONG_CYC);
        default: tmr[g].load = 21'(BLANK_SHORT_CYC);
      endcase
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
        rx_data_r <= 1'b0;
      end else begin
        rx_data_r <= rx_flt_r & ~tmr[g].busy & ~chan_off_r;
      end
    end

    // Short to ground filter and switch off
    always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
        stg_cnt_r <= 10'h000;
        stg_fault_r <= 1'b0;
        chan_off_r <= 1'b0;
      end else begin
        if (!stg_s2_r) begin
          stg_cnt_r <= 10'h000;
          stg_fault_r <= 1'b0;
        end else if (stg_cnt_r >= 10'(STG_CYC - 1)) begin
          stg_fault_r <= 1'b1;
        end else begin
          stg_cnt_r <= stg_cnt_r + 10'h001;
        end
        chan_off_r <= stg_fault_r & ~tune[`PRXA_F_KEEP_ON];
      end
    end

    // Base and peak tracking
    assign meas = {1'b0, meas_level_i[g]};
    assign step = tune[`PRXA_F_FAST] ? 11'(`PRXA_FAST_STEP) : 11'h001;
    assign freeze = frame_active_i[g] & ~tune[`PRXA_F_HOLD_DIS];

    always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
        base_r <= 11'h000;
      end else if (meas_valid_i[g] && !freeze && !rx_flt_r) begin
        if (meas > base_r + step) begin
          base_r <= base_r + step;
        end else if (meas + step < base_r) begin
          base_r <= base_r - step;
        end else begin
          base_r <= meas;
        end
      end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
        peak_r <= 11'h000;
      end else if (meas_valid_i[g]) begin
        if (meas > peak_r) begin
          peak_r <= meas;
        end else if (!rx_flt_r && peak_r > base_r) begin
          peak_r <= peak_r - 11'h001;
        end
      end
    end

    // Threshold selection
    always_comb begin
      ofs_fix = THR_OFS_W +
                ((11'(tune[`PRXA_F_LVL_HI:`PRXA_F_LVL_LO]) * 11'(THR_STEP2)) >> 1);
      ofs_ad = THR_OFS_W;
      if (peak_r > base_r && ((peak_r - base_r) >> 1) > THR_OFS_W) begin
        ofs_ad = (peak_r - base_r) >> 1;
      end
      thr_sum = base_r + (tune[`PRXA_F_TTYPE] ? ofs_fix : ofs_ad);
      if (thr_sum > LVL_MAX) begin
        thr_sum = LVL_MAX;
      end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
        thr_r <= 10'h000;
        margin_r <= 10'h000;
      end else begin
        thr_r <= thr_sum[9:0];
        margin_r <= thr_sum[9:0] - base_r[9:0];
      end
    end

    assign base_lvl[g] = base_r[9:0];
    assign margin_lvl[g] = margin_r;
    assign trip_lvl[g] = thr_r;

    // Decoder qualification
    always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
        long_err_r <= 1'b0;
        clr_r <= 1'b0;
      end else begin
        long_err_r <= long_bit_i[g] & dec_opt_r[`PRXA_F_LONG1 + SH];
        clr_r <= start_bit_err_i[g] & dec_opt_r[`PRXA_F_CLR1 + SH];
      end
    end

    assign err_any[g] = dec_err_i[g] | long_err_r;
    assign rx_data_o[g] = rx_data_r;
    assign chan_off_o[g] = chan_off_r;
    assign thr_level_o[g] = thr_r;
    assign long_bit_err_o[g] = long_err_r;
    assign bit_cnt_clr_o[g] = clr_r;
    assign period_meas_en_o[g] = ~dec_opt_r[`PRXA_F_PER_OFF1 + SH];
    assign duty_check_en_o[g] = ~dec_opt_r[`PRXA_F_DUTY_OFF1 + SH];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Loop restart after decoder error

  prxa_pkg::prxa_loop_t loop_r;

  assign tmr[2].start = (loop_r == prxa_pkg::PRXA_LOOP_IDLE) & (|err_any) &
                        dec_opt_r[`PRXA_F_LOOP_DLY];
  assign tmr[2].load = 21'(LOOP_DLY_CYC);

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      loop_r <= prxa_pkg::PRXA_LOOP_IDLE;
    end else begin
      case (loop_r)
        prxa_pkg::PRXA_LOOP_IDLE: begin
          if (|err_any) begin
            loop_r <= dec_opt_r[`PRXA_F_LOOP_DLY] ? prxa_pkg::PRXA_LOOP_WAIT
                                                   : prxa_pkg::PRXA_LOOP_FIRE;
          end
        end
        prxa_pkg::PRXA_LOOP_WAIT: begin
          if (tmr[2].done) begin
            loop_r <= prxa_pkg::PRXA_LOOP_FIRE;
          end
        end
        default: loop_r <= prxa_pkg::PRXA_LOOP_IDLE;
      endcase
    end
  end

  assign fll_reset_o = (loop_r == prxa_pkg::PRXA_LOOP_FIRE);

  ////////////////////////////////////////////////////////////////////////////
  // Sync pulses

  logic auto_both;
  logic [2:0] sync_code;
  logic [1:0] sync_r;

  assign auto_both = &auto_sync_i;
  assign sync_code = dec_opt_r[`PRXA_F_SYNC_HI:`PRXA_F_SYNC_LO];
  assign tmr[3].start = auto_both & sync_trig_i[0] & (sync_code != 3'h0);
  assign tmr[3].load = 21'(sync_code) * 21'(SYNC_STEP_CYC);

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sync_r <= 2'b00;
    end else begin
      sync_r[0] <= sync_trig_i[0];
      if (!auto_both) begin
        sync_r[1] <= sync_trig_i[1];
      end else if (sync_code == 3'h0) begin
        sync_r[1] <= sync_trig_i[0];
      end else begin
        sync_r[1] <= tmr[3].done;
      end
    end
  end

  assign sync_o = sync_r;

endmodule

`default_nettype wire

// >>> hdl/prxa_timer.sv
`timescale 1ns/1ps
`default_nettype none

module prxa_timer (
  input wire logic clk_i,
  input wire logic resetn_i,
  prxa_tmr_if.timer t
);

  logic [20:0] cnt_r;
  logic busy_r;
  logic done_r;

  // Down counter, a start while running restarts it
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt_r <= 21'h000000;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end else if (t.start) begin
      cnt_r <= t.load;
      busy_r <= (t.load != 21'h000000);
      done_r <= (t.load == 21'h000000);
    end else if (busy_r) begin
      cnt_r <= cnt_r - 21'h000001;
      busy_r <= (cnt_r != 21'h000001);
      done_r <= (cnt_r == 21'h000001);
    end else begin
      done_r <= 1'b0;
    end
  end

  assign t.busy = busy_r;
  assign t.done = done_r;

endmodule

`default_nettype wire

// >>> hdl/prxa_tmr_if.sv
`timescale 1ns/1ps
`default_nettype none

interface prxa_tmr_if;
  logic start;
  logic [20:0] load;
  logic busy;
  logic done;

  modport timer (input start, input load, output busy, output done);
  modport user (output start, output load, input busy, input done);
endinterface

`default_nettype wire

// >>> testbench/prxa_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module prxa_host_model (
  input wire logic clk_i,
  output logic [5:0] addr_o,
  output logic [15:0] wdata_o,
  output logic wr_o,
  output logic rd_o
);
  initial begin
    addr_o = 6'h00;
    wdata_o = 16'h0000;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end
  // Released lines show the inverse, never the last value
  task wr(input logic [5:0] a, input logic [15:0] d);
    @(negedge clk_i);
    addr_o = a;
    wdata_o = d;
    wr_o = 1'b1;
    @(negedge clk_i);
    wr_o = 1'b0;
    addr_o = ~a;
    wdata_o = ~d;
  endtask
  task rd(input logic [5:0] a);
    @(negedge clk_i);
    addr_o = a;
    rd_o = 1'b1;
    @(negedge clk_i);
    rd_o = 1'b0;
    addr_o = ~a;
  endtask
endmodule
`default_nettype wire

// >>> testbench/prxa_rx_settings_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module prxa_rx_settings_monitor (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [15:0] reg_rdata_o,
  input wire logic prog_end_i,
  input wire logic prog_done_o,
  input wire logic [1:0] stg_i,
  input wire logic [1:0] chan_off_o,
  input wire logic [1:0] long_bit_i,
  input wire logic [1:0] long_bit_err_o,
  input wire logic [1:0] start_bit_err_i,
  input wire logic [1:0] bit_cnt_clr_o,
  input wire logic fll_reset_o,
  input wire logic [1:0] period_meas_en_o,
  input wire logic [1:0] duty_check_en_o,
  input wire logic [1:0] auto_sync_i,
  input wire logic [1:0] sync_trig_i,
  input wire logic [1:0] sync_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  chk_long_bit_cause: assert property (
    long_bit_err_o[0] |-> $past(long_bit_i[0])) else $error("long bit error without cause");
  chk_clear_cause: assert property (
    bit_cnt_clr_o[0] |-> $past(start_bit_err_i[0])) else $error("counter clear without cause");
  chk_loop_pulse: assert property (
    fll_reset_o |=> !fll_reset_o) else $error("loop restart longer than one cycle");
  chk_short_filter: assert property (
    $rose(chan_off_o[0]) |-> $past(stg_i[0], 8)) else $error("channel off without long short");
  chk_sync_first: assert property (
    sync_trig_i[0] |=> sync_o[0]) else $error("channel 1 sync missing");
  chk_sync_manual: assert property (
    sync_trig_i[1] && !(&auto_sync_i) |=> sync_o[1]) else $error("channel 2 sync missing");
  chk_prog_set: assert property (
    prog_end_i |=> prog_done_o) else $error("programming flag not set");
  chk_prog_hold: assert property (
    prog_done_o |=> prog_done_o) else $error("programming flag dropped");
  chk_read_hold: assert property (
    !reg_rd_i |=> $stable(reg_rdata_o)) else $error("read data changed without read");
  chk_option_hold: assert property (
    !reg_wr_i |=> $stable({period_meas_en_o, duty_check_en_o})) else $error("options moved");
endmodule
bind prxa_rx_settings prxa_rx_settings_monitor prxa_rx_settings_monitor_inst (.clk_i, .resetn_i,
  .reg_wr_i, .reg_rd_i, .reg_rdata_o, .prog_end_i, .prog_done_o, .stg_i, .chan_off_o,
  .long_bit_i, .long_bit_err_o, .start_bit_err_i, .bit_cnt_clr_o, .fll_reset_o,
  .period_meas_en_o, .duty_check_en_o, .auto_sync_i, .sync_trig_i, .sync_o);
`default_nettype wire

// >>> testbench/prxa_rx_settings_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin num_errors++; \
  $display("[FAIL] %0t got %0h exp %0h", $time, (g), (e)); end end
`define WAITN(c) begin n = 1; while (!(c) && n < 3000) begin @(negedge clk_i); n++; end \
  if (n >= 3000) begin num_errors++; complete_run(); end end
module prxa_rx_settings_tb;
  logic clk_i, resetn_i, reg_wr_i, reg_rd_i, prog_end_i, prog_done_o, rate_189k_i, fll_reset_o;
  logic [5:0] reg_addr_i;
  logic [15:0] reg_wdata_i, reg_rdata_o, v, exp_v;
  logic [1:0] rx_i, stg_i, sensor_start_i, frame_active_i, meas_valid_i, rx_data_o, chan_off_o;
  logic [1:0] long_bit_i, start_bit_err_i, dec_err_i, long_bit_err_o, period_meas_en_o;
  logic [1:0] duty_check_en_o, bit_cnt_clr_o, auto_sync_i, sync_trig_i, sync_o;
  logic [1:0][9:0] meas_level_i, thr_level_o;
  logic [15:0] exp_q[$];
  logic rd_q;
  int num_errors, tests_run, seed, n, k;
  prxa_rx_settings #(.BLANK_SHORT_CYC(20), .BLANK_MID_CYC(50), .BLANK_LONG_CYC(100),
    .LOOP_DLY_CYC(200)) prxa_rx_settings_inst (.clk_i, .resetn_i, .reg_addr_i, .reg_wdata_i,
    .reg_wr_i, .reg_rd_i, .reg_rdata_o, .prog_end_i, .prog_done_o, .rate_189k_i, .rx_i, .stg_i,
    .sensor_start_i, .frame_active_i, .meas_valid_i, .meas_level_i, .rx_data_o, .chan_off_o,
    .thr_level_o, .long_bit_i, .start_bit_err_i, .dec_err_i, .long_bit_err_o, .period_meas_en_o,
    .duty_check_en_o, .bit_cnt_clr_o, .fll_reset_o, .auto_sync_i, .sync_trig_i, .sync_o);
  prxa_host_model prxa_host_model_inst (.clk_i, .addr_o(reg_addr_i), .wdata_o(reg_wdata_i),
    .wr_o(reg_wr_i), .rd_o(reg_rd_i));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Read result checker
  always @(posedge clk_i) rd_q <= reg_rd_i;
  always @(negedge clk_i) begin
    if (rd_q === 1'b1) begin
      exp_v = exp_q.pop_front();
      `CHK(reg_rdata_o, exp_v)
    end
  end
  task rd_exp(input logic [5:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    prxa_host_model_inst.rd(a);
  endtask
  task meas_pulses(input int k);
    repeat (k) begin
      meas_valid_i = 2'b01;
      @(negedge clk_i);
      meas_valid_i = 2'b00;
      @(negedge clk_i);
    end
  endtask
  task blank_len(output int c);
    sensor_start_i = 2'b01;
    @(negedge clk_i);
    sensor_start_i = 2'b00;
    @(negedge clk_i);
    `CHK(rx_data_o[0], 1'b0)
    `WAITN(rx_data_o[0] === 1'b1)
    c = n;
  endtask
  task test_done(input string s);
    $display("Test %s done", s);
  endtask
  task complete_run();
    $display("Checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #1_000_000;
    num_errors++;
    complete_run();
  end
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {resetn_i, prog_end_i, rate_189k_i, rx_i, stg_i, sensor_start_i, frame_active_i} = '0;
    {meas_valid_i, meas_level_i, long_bit_i, start_bit_err_i, dec_err_i} = '0;
    {auto_sync_i, sync_trig_i} = '0;
    seed = 50003;
    repeat (16) @(posedge clk_i);
    @(negedge clk_i);
    resetn_i = 1'b1;
    rd_exp(6'h2e, 16'h4400);
    rd_exp(6'h2f, 16'h0000);
    rd_exp(6'h30, 16'h4400);
    rd_exp(6'h31, 16'h0000);
    test_done("reset");
    for (int i = 0; i < 3; i++) prxa_host_model_inst.wr(6'h2e + 6'(i), 16'hffff);
    prxa_host_model_inst.wr(6'h32, 16'hffff);
    rd_exp(6'h2e, 16'hfbfd);
    rd_exp(6'h2f, 16'h9e7f);
    rd_exp(6'h30, 16'hfbfd);
    rd_exp(6'h32, 16'h0000);
    repeat (3) begin
      v = 16'($random(seed));
      prxa_host_model_inst.wr(6'h2e, v);
      rd_exp(6'h2e, v & 16'hfbfd);
    end
    test_done("masks");
    prxa_host_model_inst.wr(6'h2f, 16'h085b);
    @(negedge clk_i);
    `CHK(period_meas_en_o, 2'b01)
    `CHK(duty_check_en_o, 2'b10)
    long_bit_i = 2'b11;
    start_bit_err_i = 2'b11;
    @(negedge clk_i);
    {long_bit_i, start_bit_err_i} = '0;
    `CHK(long_bit_err_o, 2'b01)
    `CHK(bit_cnt_clr_o, 2'b01)
    repeat (5) @(negedge clk_i);
    dec_err_i = 2'b01;
    @(negedge clk_i);
    dec_err_i = 2'b00;
    `WAITN(fll_reset_o === 1'b1)
    `CHK(n <= 3, 1'b1)
    auto_sync_i = 2'b11;
    sync_trig_i = 2'b11;
    @(negedge clk_i);
    sync_trig_i = 2'b00;
    `WAITN(sync_o[1] === 1'b1)
    `CHK(n inside {[600:603]}, 1'b1)
    auto_sync_i = 2'b01;
    sync_trig_i = 2'b10;
    @(negedge clk_i);
    sync_trig_i = 2'b00;
    `CHK(sync_o, 2'b10)
    prxa_host_model_inst.wr(6'h2f, 16'h885b);
    dec_err_i = 2'b01;
    @(negedge clk_i);
    dec_err_i = 2'b00;
    `WAITN(fll_reset_o === 1'b1)
    `CHK(n inside {[200:204]}, 1'b1)
    test_done("decoder");
    prxa_host_model_inst.wr(6'h2e, 16'h2201);
    meas_level_i[0] = 10'd100;
    meas_pulses(4);
    rd_exp(6'h32, 16'd32);
    meas_pulses(20);
    rd_exp(6'h32, 16'd100);
    rd_exp(6'h33, 16'd126);
    rd_exp(6'h34, 16'd226);
    `CHK(thr_level_o[0], 10'd226)
    frame_active_i = 2'b01;
    meas_level_i[0] = 10'd300;
    meas_pulses(4);
    rd_exp(6'h32, 16'd100);
    frame_active_i = 2'b00;
    test_done("levels");
    rate_189k_i = 1'b1;
    rx_i = 2'b01;
    `WAITN(rx_data_o[0] === 1'b1)
    `CHK(n inside {[103:105]}, 1'b1)
    blank_len(k);
    `CHK(k inside {[20:22]}, 1'b1)
    prxa_host_model_inst.wr(6'h2e, 16'h2281);
    blank_len(k);
    `CHK(k inside {[50:52]}, 1'b1)
    rate_189k_i = 1'b0;
    rx_i = 2'b00;
    `WAITN(rx_data_o[0] === 1'b0)
    `CHK(n inside {[153:155]}, 1'b1)
    rx_i = 2'b01;
    repeat (120) @(negedge clk_i);
    `CHK(rx_data_o[0], 1'b0)
    rx_i = 2'b00;
    prxa_host_model_inst.wr(6'h2e, 16'h2280);
    @(negedge clk_i);
    `CHK(thr_level_o[0], 10'd199)
    test_done("receive");
    prxa_host_model_inst.wr(6'h30, 16'h8000);
    stg_i = 2'b11;
    `WAITN(chan_off_o[0] === 1'b1)
    `CHK(n inside {[1000:1006]}, 1'b1)
    `CHK(chan_off_o[1], 1'b0)
    stg_i = 2'b00;
    test_done("short");
    prog_end_i = 1'b1;
    @(negedge clk_i);
    prog_end_i = 1'b0;
    `CHK(prog_done_o, 1'b1)
    prxa_host_model_inst.wr(6'h2e, 16'h0000);
    rd_exp(6'h2e, 16'h2280);
    test_done("program end");
    complete_run();
  end
endmodule
`default_nettype wire
